// >>> include/spi_frame_pkg.sv
// constants, encodings and types for the spi frame and crc block
// How it works
// - frame bits 6..0 carry the register address
// - bit 7 picks read-only versus write or read-and-clear
// - sixteen payload bits sit at frame bits 23..8
// - status bits stay set until a read-and-clear; whole-register access
// - in restart mode no received frame is interpreted
// - an addressed status register is returned in the same frame
// - config writes land at chip select rise; the frame shows old contents
// - control writes accepted in init or normal mode, and in stop mode only as below
// - stop mode allows only mode change, watchdog, status read or clear
// - late events still set flags; summary shows them next frame
// - summary bits 0..3 are OR of supply, thermal, bus, wake status
// - summary bit 4 ORs high-side status, bit 6 ORs drain-source status
// - summary bit 5 ORs device status except crc-status and software_development_bit bits
// - summary bit 7 is command-failure OR crc-failure
// - frame bits 31..24 carry an eight-bit check on both directions
// - check: poly 2F, init FF, no reflection, final xor FF
// - check covers frame bits 0..23, separately for in and out words
// - output payload shows data previously written to the register
// - reading the device status register ignores the check byte
// - checking on and wrong check byte sets crc failure
// - checking off, upper byte other than A5 sets crc failure
// - checking off, device always sends 5A in bits 31..24
// - read-only crc status bit mirrors whether checking is enabled
// - sample input on falling clock, shift output after rising clock
// - at chip select rise interpret word and release serial output
// - clock count not 0 or 32 discards frame and flags next frame
package spi_frame_pkg;
   // ***********************************
   // frame layout
   // ***********************************
   localparam int FRAME_BITS = 32;
   localparam int PAY_BITS = 24;
   localparam logic [5:0] FRAME_CNT = 6'h20;
   localparam logic [5:0] ADDR_DONE_CNT = 6'h06;
   localparam logic [5:0] CNT_SAT = 6'h3F;
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [2:0] CS_SYNC_RST = 3'h7;
   // ***********************************
   // check byte
   // ***********************************
   localparam logic [7:0] CRC_POLY = 8'h2F;
   localparam logic [7:0] CRC_INIT = 8'hFF;
   localparam logic [7:0] CRC_XOR = 8'hFF;
   localparam logic [7:0] CRC_OFF_IN = 8'hA5;
   localparam logic [7:0] CRC_OFF_OUT = 8'h5A;
   // ***********************************
   // register addresses
   // ***********************************
   localparam logic [6:0] CFG_DEV_LO = 7'h01;
   localparam logic [6:0] CFG_DEV_HI = 7'h0B;
   localparam logic [6:0] CFG_BD_LO = 7'h10;
   localparam logic [6:0] CFG_BD_HI = 7'h1D;
   localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
   localparam logic [6:0] WD_CTRL_ADDR = 7'h03;
   localparam logic [6:0] SUP_STAT_ADDR = 7'h40;
   localparam logic [6:0] THERMAL_STATUS_REG_ADDR = 7'h41;
   localparam logic [6:0] BUS_STAT_ADDR = 7'h42;
   localparam logic [6:0] WAKE_STAT_ADDR = 7'h43;
   localparam logic [6:0] SUMMARY_HIGH_SIDE_BIT_ADDR = 7'h44;
   localparam logic [6:0] DEV_STAT_ADDR = 7'h45;
   localparam logic [6:0] DS_STAT_ADDR = 7'h50;
   // status array index, equal to the summary bit it feeds
   localparam logic [2:0] IDX_DEV = 3'h5;
   localparam logic [2:0] IDX_NONE = 3'h7;
   // device status bit positions
   localparam int DEV_CRC_STAT_BIT = 15;
   localparam int DEV_CRC_FAIL_BIT = 14;
   localparam int DEV_SPI_FAIL_BIT = 13;
   localparam int DEV_SOFTWARE_DEVELOPMENT_BIT_BIT = 12;
   localparam logic [15:0] DEV_SUM_MASK = 16'h6FFF;
   // ***********************************
   // device modes and frame states
   // ***********************************
   localparam logic [1:0] MODE_INIT = 2'h0;
   localparam logic [1:0] MODE_NORMAL = 2'h1;
   localparam logic [1:0] MODE_STOP = 2'h2;
   localparam logic [1:0] MODE_RESTART = 2'h3;
   typedef enum logic {FR_IDLE, FR_ACTIVE} frame_state_t;
endpackage

// >>> core/spi_frame_crc.sv
// spi slave frame engine with check byte, status summary and mode gating
`timescale 1ns/1ps
module spi_frame_crc
   import spi_frame_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic chip_select_n_i,
   input wire logic spi_clk_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   input wire logic crc_en_i,
   input wire logic [1:0] dev_mode_i,
   input wire logic [15:0] sup_set_i,
   input wire logic [15:0] therm_set_i,
   input wire logic [15:0] bus_set_i,
   input wire logic [15:0] wake_set_i,
   input wire logic [15:0] hs_set_i,
   input wire logic [15:0] dev_set_i,
   input wire logic [15:0] ds_set_i,
   output logic cfg_wr_o,
   output logic [6:0] cfg_addr_o,
   output logic [15:0] cfg_data_o,
   output logic [7:0] status_summary_o
);

   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] sck_s;
      logic [1:0] sdi_s;
      logic [1:0] crc_s;
      frame_state_t st;
      logic [5:0] fcnt;
      logic [5:0] rcnt;
      logic [31:0] rx;
      logic [23:0] tx;
      logic err;
      logic serial_out;
      logic oe;
      logic [6:0][15:0] stat;
      logic [31:0][15:0] cfg;
      logic wr;
      logic [6:0] waddr;
      logic [15:0] wdata;
   } state_t;

   state_t q;
   state_t d;
   logic cs_fall;
   logic cs_rise;
   logic sck_fall;
   logic sck_rise;
   logic crc_en;
   logic [6:0] addr;
   logic [6:0] addr_early;
   logic [2:0] sidx;
   logic rx_ok;
   logic dev_rd;
   logic mode_ok;
   logic [7:0] tx_crc;
   logic [6:0][15:0] set_v;
   logic [6:0][15:0] clr;
   logic [15:0] dev_flag;
   logic [2:0] sidx_early;
   logic frame_ok;

   // ***********************************
   // helpers
   // ***********************************
   // bits 23 down to 0, so the top byte goes first, msb first
   function automatic logic [7:0] crc8(input logic [23:0] v);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = PAY_BITS - 1; i >= 0; i--) begin
         if (c[7] ^ v[i]) begin
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c ^ CRC_XOR;
   endfunction

   function automatic logic is_cfg(input logic [6:0] a);
      return (a >= CFG_DEV_LO && a <= CFG_DEV_HI) ||
             (a >= CFG_BD_LO && a <= CFG_BD_HI);
   endfunction

   function automatic logic [2:0] stat_idx(input logic [6:0] a);
      case (a)
         SUP_STAT_ADDR: return 3'h0;
         THERMAL_STATUS_REG_ADDR: return 3'h1;
         BUS_STAT_ADDR: return 3'h2;
         WAKE_STAT_ADDR: return 3'h3;
         SUMMARY_HIGH_SIDE_BIT_ADDR: return 3'h4;
         DEV_STAT_ADDR: return IDX_DEV;
         DS_STAT_ADDR: return 3'h6;
         default: return IDX_NONE;
      endcase
   endfunction

   // summary byte; array order matches summary bit order
   function automatic logic [7:0] summ(input logic [6:0][15:0] s);
      logic [7:0] r;
      r[0] = |s[0];
      r[1] = |s[1];
      r[2] = |s[2];
      r[3] = |s[3];
      r[4] = |s[4];
      r[5] = |(s[5] & DEV_SUM_MASK);
      r[6] = |s[6];
      r[7] = s[5][DEV_SPI_FAIL_BIT] | s[5][DEV_CRC_FAIL_BIT];
      return r;
   endfunction

   // ***********************************
   // edges and frame decode
   // ***********************************
   // edges only look at the second and third stages
   assign cs_fall = q.cs_s[2] & ~q.cs_s[1];
   assign cs_rise = ~q.cs_s[2] & q.cs_s[1];
   assign sck_fall = q.sck_s[2] & ~q.sck_s[1] & q.st == FR_ACTIVE;
   assign sck_rise = ~q.sck_s[2] & q.sck_s[1] & q.st == FR_ACTIVE;
   assign crc_en = q.crc_s[1];
   assign addr = q.rx[6:0];
   assign addr_early = {q.sdi_s[1], q.rx[5:0]};
   assign sidx = stat_idx(addr);
   assign sidx_early = stat_idx(addr_early);
   assign dev_rd = addr == DEV_STAT_ADDR && !q.rx[7];
   // only a whole frame outside restart mode is interpreted
   assign frame_ok = cs_rise && q.fcnt == FRAME_CNT &&
                     dev_mode_i != MODE_RESTART;
   // check over bits 23..0 of the received word
   assign rx_ok = crc_en ? q.rx[31:24] == crc8(q.rx[23:0])
                         : q.rx[31:24] == CRC_OFF_IN;
   assign mode_ok = dev_mode_i == MODE_INIT ||
                    dev_mode_i == MODE_NORMAL ||
                    (dev_mode_i == MODE_STOP &&
                     (addr == MODE_CTRL_ADDR || addr == WD_CTRL_ADDR));
   // separate check over the outgoing word
   assign tx_crc = crc_en ? crc8(q.tx) : CRC_OFF_OUT;
   assign set_v = {ds_set_i, dev_set_i, hs_set_i, wake_set_i,
                   bus_set_i, therm_set_i, sup_set_i};

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      d = q;
      clr = '0;
      dev_flag = '0;
      d.cs_s = {q.cs_s[1:0], chip_select_n_i};
      d.sck_s = {q.sck_s[1:0], spi_clk_i};
      d.sdi_s = {q.sdi_s[0], serial_in_i};
      d.crc_s = {q.crc_s[0], crc_en_i};
      d.wr = 1'b0;
      // frame start: summary frozen here, later events wait a frame
      if (cs_fall) begin
         d.st = FR_ACTIVE;
         d.fcnt = '0;
         d.rcnt = '0;
         d.rx = '0;
         d.tx = {16'h0000, summ(q.stat)};
         d.serial_out = q.err;
         d.oe = 1'b1;
      end else if (cs_rise) begin
         // word interpreted only now, and the line is released
         d.st = FR_IDLE;
         d.oe = 1'b0;
         d.serial_out = 1'b0;
         d.err = q.fcnt != 6'h00 && q.fcnt != FRAME_CNT;
         if (frame_ok) begin
            if (!rx_ok && !dev_rd) begin
               dev_flag[DEV_CRC_FAIL_BIT] = 1'b1;
            end else if (q.rx[7]) begin
               if (sidx != IDX_NONE) begin
                  clr[sidx] = 16'hFFFF;
               end else if (is_cfg(addr)) begin
                  if (mode_ok) begin
                     d.cfg[addr[4:0]] = q.rx[23:8];
                     d.wr = 1'b1;
                     d.waddr = addr;
                     d.wdata = q.rx[23:8];
                  end else begin
                     dev_flag[DEV_SPI_FAIL_BIT] = 1'b1;
                  end
               end
            end
         end
      end else begin
         // input sampled on the falling clock, lsb of the frame first
         if (sck_fall) begin
            if (q.fcnt < FRAME_CNT) begin
               d.rx[q.fcnt[4:0]] = q.sdi_s[1];
            end
            if (q.fcnt != CNT_SAT) begin
               d.fcnt = q.fcnt + 6'h01;
            end
            // address complete: load payload for this same frame
            if (q.fcnt == ADDR_DONE_CNT) begin
               if (sidx_early != IDX_NONE) begin
                  d.tx[23:8] = q.stat[sidx_early];
               end else if (is_cfg(addr_early)) begin
                  d.tx[23:8] = q.cfg[addr_early[4:0]];
               end else begin
                  d.tx[23:8] = REG_RST;
               end
            end
         end
         // output moves after each rising clock; beyond 32 it idles low
         if (sck_rise) begin
            if (q.rcnt < 6'h18) begin
               d.serial_out = q.tx[q.rcnt[4:0]];
            end else if (q.rcnt < FRAME_CNT) begin
               d.serial_out = tx_crc[q.rcnt[2:0]];
            end else begin
               d.serial_out = 1'b0;
            end
            if (q.rcnt != CNT_SAT) begin
               d.rcnt = q.rcnt + 6'h01;
            end
         end
      end
      // hardware set wins over a clear in the same cycle
      for (int i = 0; i < 7; i++) begin
         d.stat[i] = (q.stat[i] & ~clr[i]) | set_v[i];
      end
      d.stat[IDX_DEV] = d.stat[IDX_DEV] | dev_flag;
      d.stat[IDX_DEV][DEV_CRC_STAT_BIT] = crc_en;
   end

   // select synchroniser starts at the pin's idle level: no false frame end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.cs_s <= CS_SYNC_RST;
      end else begin
         q <= d;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign serial_out_o = q.serial_out;
   assign serial_out_oe_o = q.oe;
   assign cfg_wr_o = q.wr;
   assign cfg_addr_o = q.waddr;
   assign cfg_data_o = q.wdata;
   assign status_summary_o = q.tx[7:0];

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_oe_release: assert property (cs_rise |=> !serial_out_oe_o)
      else $error("serial out not released at frame end");
   chk_err_shown: assert property (
      cs_fall && q.err |=> serial_out_o && serial_out_oe_o)
      else $error("frame error not shown at frame start");
   chk_bad_count: assert property (
      cs_rise && q.fcnt != 6'h00 && q.fcnt != FRAME_CNT
      |=> q.err && !cfg_wr_o)
      else $error("bad clock count not discarded");
   chk_write_at_rise: assert property (cfg_wr_o |-> $past(cs_rise))
      else $error("config write outside frame end");
   chk_restart_ignore: assert property (
      cs_rise && dev_mode_i == MODE_RESTART |=> !cfg_wr_o)
      else $error("frame interpreted in restart mode");
   chk_stop_writes: assert property (
      cfg_wr_o && $past(dev_mode_i) == MODE_STOP
      |-> cfg_addr_o == MODE_CTRL_ADDR || cfg_addr_o == WD_CTRL_ADDR)
      else $error("forbidden write taken in stop mode");
   chk_crc_stat_bit: assert property (
      q.stat[IDX_DEV][DEV_CRC_STAT_BIT] == $past(crc_en))
      else $error("crc status bit does not follow setting");
   chk_sticky_status: assert property (
      (|($past(q.stat[0]) & ~q.stat[0])) |-> $past(cs_rise))
      else $error("status bit dropped without a clear");
   chk_summary_latch: assert property (
      cs_fall |=> status_summary_o == summ($past(q.stat)))
      else $error("summary byte not taken at frame start");
   chk_crc_off_out: assert property (
      sck_rise && !crc_en && q.rcnt == 6'h18 |=> serial_out_o == 1'b0)
      else $error("fixed out pattern bit 24 wrong");

   // ***********************************
   // serial path and frame end checks
   // ***********************************
   // the serial checks skip the frame end cycle, which overrides the shifter
   chk_in_sample: assert property (
      sck_fall && !cs_rise && q.fcnt < FRAME_CNT
      |=> q.rx[$past(q.fcnt[4:0])] == $past(q.sdi_s[1]))
      else $error("input bit not taken on falling clock");
   chk_out_bit: assert property (
      sck_rise && !cs_rise && q.rcnt < 6'h18
      |=> serial_out_o == $past(q.tx[q.rcnt[4:0]]))
      else $error("output bit not shifted after rising clock");
   chk_off_pattern: assert property (
      sck_rise && !cs_rise && !crc_en && q.rcnt >= 6'h18 && q.rcnt < FRAME_CNT
      |=> serial_out_o == $past(CRC_OFF_OUT[q.rcnt[2:0]]))
      else $error("fixed out pattern wrong");
   chk_stat_payload: assert property (
      sck_fall && !cs_rise && q.fcnt == ADDR_DONE_CNT && sidx_early != IDX_NONE
      |=> q.tx[23:8] == $past(q.stat[sidx_early]))
      else $error("status payload not loaded in this frame");
   chk_cfg_payload: assert property (
      sck_fall && !cs_rise && q.fcnt == ADDR_DONE_CNT && is_cfg(addr_early)
      |=> q.tx[23:8] == $past(q.cfg[addr_early[4:0]]))
      else $error("config payload not the stored value");
   chk_crc_fail_set: assert property (
      frame_ok && !rx_ok && !dev_rd
      |=> q.stat[IDX_DEV][DEV_CRC_FAIL_BIT] && !cfg_wr_o)
      else $error("wrong check byte not flagged");
   chk_dev_read_free: assert property (
      cs_rise && dev_rd && dev_set_i == 16'h0000 &&
      !q.stat[IDX_DEV][DEV_CRC_FAIL_BIT]
      |=> !q.stat[IDX_DEV][DEV_CRC_FAIL_BIT])
      else $error("device status read raised a failure flag");
   chk_restart_quiet: assert property (
      cs_rise && dev_mode_i == MODE_RESTART && dev_set_i == 16'h0000 &&
      !q.stat[IDX_DEV][DEV_CRC_FAIL_BIT]
      |=> !q.stat[IDX_DEV][DEV_CRC_FAIL_BIT])
      else $error("frame in restart mode raised a failure flag");
   chk_status_clear: assert property (
      frame_ok && rx_ok && q.rx[7] && sidx != IDX_DEV && sidx != IDX_NONE
      |=> q.stat[$past(sidx)] == $past(set_v[sidx]))
      else $error("status register not cleared as a whole");
   chk_write_data: assert property (
      cfg_wr_o |-> cfg_data_o == $past(q.rx[23:8]) &&
      cfg_addr_o == $past(addr))
      else $error("written data or address wrong");
   chk_init_write: assert property (
      frame_ok && rx_ok && q.rx[7] && is_cfg(addr) &&
      (dev_mode_i == MODE_INIT || dev_mode_i == MODE_NORMAL) |=> cfg_wr_o)
      else $error("config write refused in init or normal mode");
   chk_stop_fail: assert property (
      frame_ok && rx_ok && q.rx[7] && is_cfg(addr) && !mode_ok
      |=> q.stat[IDX_DEV][DEV_SPI_FAIL_BIT] && !cfg_wr_o)
      else $error("forbidden stop mode write not flagged");
endmodule

// >>> testbench/spi_host_model.sv
// host side model that clocks frames of a given clock count through the device link
`timescale 1ns/1ps
module spi_host_model (
   input wire logic sys_clk_i,
   input wire logic serial_out_i,
   output logic chip_select_n_o,
   output logic spi_clk_o,
   output logic serial_in_o
);
   // idle: select high, link clock parked low
   initial begin
      chip_select_n_o = 1'h1;
      spi_clk_o = 1'h0;
      serial_in_o = 1'h0;
   end
   // ************************************
   // frame transfer, 80 ns link clock
   // ************************************
   // the link clock only runs inside a frame and is low at select edges
   task automatic frame(input logic [31:0] din, input int nclk,
         output logic [31:0] dout, output logic err);
      dout = 32'h0000_0000;
      @(posedge sys_clk_i);
      #1;
      chip_select_n_o = 1'h0;
      #40;
      err = serial_out_i;
      for (int k = 0; k < nclk; k++) begin
         spi_clk_o = 1'h1;
         serial_in_o = din[k];
         #40;
         spi_clk_o = 1'h0;
         dout[k] = serial_out_i;
         #40;
      end
      // released data line flips so a stale bit is never mistaken for data
      serial_in_o = ~serial_in_o;
      chip_select_n_o = 1'h1;
      #40;
   endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the spi frame and check byte engine
`timescale 1ns/1ps
module tb_top;
   import spi_frame_pkg::*;
   typedef struct {
      logic [1:0] md;
      logic [6:0] a;
      logic w;
      logic [15:0] d;
      logic bad;
      logic wok;
      logic [15:0] pay;
      logic [7:0] sum;
   } row_t;
   logic sys_clk = 1'h0;
   logic rst, cs_n, sclk, sin, sout, oe, crc_en, cfg_wr, err;
   logic [1:0] mode;
   logic [6:0] cfg_addr;
   logic [15:0] cfg_data, exp;
   logic [7:0] summary;
   logic [15:0] sets [7];
   logic [31:0] dout;
   logic sdo_line;
   int mismatches = 0;
   int tests_run = 0;
   int wr_seen = 0;
   int wr_before = 0;
   logic [6:0] stat_a [7] = '{SUP_STAT_ADDR, THERMAL_STATUS_REG_ADDR, BUS_STAT_ADDR,
      WAKE_STAT_ADDR, SUMMARY_HIGH_SIDE_BIT_ADDR, DEV_STAT_ADDR, DS_STAT_ADDR};
   row_t rows [13] = '{
      '{MODE_NORMAL, 7'h10, 1'h1, 16'h1234, 1'h0, 1'h1, 16'h0000, 8'h00},
      '{MODE_NORMAL, 7'h10, 1'h0, 16'h0000, 1'h0, 1'h0, 16'h1234, 8'h00},
      '{MODE_STOP, 7'h10, 1'h1, 16'h5555, 1'h0, 1'h0, 16'h1234, 8'h00},
      '{MODE_STOP, 7'h45, 1'h0, 16'h0000, 1'h0, 1'h0, 16'hA000, 8'hA0},
      '{MODE_STOP, 7'h03, 1'h1, 16'h0001, 1'h0, 1'h1, 16'h0000, 8'hA0},
      '{MODE_NORMAL, 7'h45, 1'h1, 16'hFFFF, 1'h0, 1'h0, 16'hA000, 8'hA0},
      '{MODE_NORMAL, 7'h45, 1'h0, 16'h0000, 1'h0, 1'h0, 16'h8000, 8'h00},
      '{MODE_NORMAL, 7'h10, 1'h1, 16'h9999, 1'h1, 1'h0, 16'h1234, 8'h00},
      '{MODE_NORMAL, 7'h45, 1'h0, 16'h0000, 1'h1, 1'h0, 16'hC000, 8'hA0},
      '{MODE_NORMAL, 7'h45, 1'h1, 16'hFFFF, 1'h0, 1'h0, 16'hC000, 8'hA0},
      '{MODE_NORMAL, 7'h10, 1'h0, 16'h0000, 1'h0, 1'h0, 16'h1234, 8'h00},
      '{MODE_INIT, 7'h1D, 1'h1, 16'hBEEF, 1'h0, 1'h1, 16'h0000, 8'h00},
      '{MODE_INIT, 7'h1D, 1'h0, 16'h0000, 1'h0, 1'h0, 16'hBEEF, 8'h00}};

   always #2 sys_clk = ~sys_clk;
   // accepted configuration writes show up as single-cycle pulses
   always @(posedge sys_clk) if (cfg_wr === 1'h1) wr_seen <= wr_seen + 1;

   spi_frame_crc spi_frame_crc_i (.sys_clk_i(sys_clk), .rst_i(rst),
      .chip_select_n_i(cs_n), .spi_clk_i(sclk), .serial_in_i(sin),
      .serial_out_o(sout), .serial_out_oe_o(oe), .crc_en_i(crc_en),
      .dev_mode_i(mode), .sup_set_i(sets[0]), .therm_set_i(sets[1]),
      .bus_set_i(sets[2]), .wake_set_i(sets[3]), .hs_set_i(sets[4]),
      .dev_set_i(sets[5]), .ds_set_i(sets[6]), .cfg_wr_o(cfg_wr),
      .cfg_addr_o(cfg_addr), .cfg_data_o(cfg_data),
      .status_summary_o(summary));
   // a released line shows the inverse of its last level, never stale data
   assign sdo_line = oe ? sout : ~sout;
   spi_host_model spi_host_model_i (.sys_clk_i(sys_clk),
      .serial_out_i(sdo_line),
      .chip_select_n_o(cs_n), .spi_clk_o(sclk), .serial_in_o(sin));

   // ************************************
   // helpers
   // ************************************
   // msb first over word bits 23..0, poly 2F, start FF, final xor FF
   function automatic logic [7:0] crc8(input logic [23:0] b);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'h0} ^ ((c[7] ^ b[i]) ? 8'h2F : 8'h00);
      end
      return c ^ 8'hFF;
   endfunction
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'h1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // upper byte follows the check setting; bad flips its lowest bit
   task automatic xfer(input logic [6:0] a, input logic w,
         input logic [15:0] d, input logic bad, input int n);
      logic [23:0] body;
      logic [7:0] tail;
      body = {d, w, a};
      tail = (crc_en ? crc8(body) : CRC_OFF_IN) ^ {7'h00, bad};
      wr_before = wr_seen;
      spi_host_model_i.frame({tail, body}, n, dout, err);
      if (n == 32) begin
         if (crc_en) check(dout[31:24] === crc8(dout[23:0]), "out crc");
         else check(dout[31:24] === CRC_OFF_OUT, "out pattern");
      end
      check(oe === 1'h0, "output not released");
   endtask
   task automatic look(input logic [15:0] pay, input logic [7:0] sum);
      check(dout[23:8] === pay, "payload");
      check(dout[7:0] === sum && summary === sum, "summary");
   endtask
   task automatic pulse(input int i, input logic [15:0] v);
      @(posedge sys_clk);
      #1 sets[i] = v;
      @(posedge sys_clk);
      #1 sets[i] = 16'h0000;
   endtask

   // a hang counts as a mismatch and closes the run
   initial begin
      repeat (100000) @(posedge sys_clk);
      check(1'h0, "timeout");
      report_and_stop;
   end
   // ************************************
   // main sequence
   // ************************************
   initial begin
      rst = 1'h1;
      crc_en = 1'h1;
      mode = MODE_NORMAL;
      sets = '{default: 16'h0000};
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'h0;
      repeat (8) @(posedge sys_clk);
      check({cfg_wr, cfg_addr, cfg_data, summary, oe} === '0, "reset");
      foreach (rows[i]) begin
         @(posedge sys_clk);
         #1 mode = rows[i].md;
         xfer(rows[i].a, rows[i].w, rows[i].d, rows[i].bad, 32);
         look(rows[i].pay, rows[i].sum);
         check(wr_seen - wr_before === int'(rows[i].wok), "wr");
         if (rows[i].wok) check(cfg_data === rows[i].d &&
            cfg_addr === rows[i].a, "cfg data");
      end
      @(posedge sys_clk);
      #1 mode = MODE_RESTART;
      xfer(7'h10, 1'h1, 16'h7777, 1'h0, 32);
      check(wr_seen === wr_before, "restart write");
      @(posedge sys_clk);
      #1 mode = MODE_NORMAL;
      xfer(7'h10, 1'h0, 16'h0000, 1'h0, 32);
      look(16'h1234, 8'h00);
      for (int i = 0; i < 7; i++) begin
         pulse(i, 16'h0001 << i);
         exp = (16'h0001 << i) | (i == 5 ? 16'h8000 : 16'h0000);
         xfer(stat_a[i], 1'h0, 16'h0000, 1'h0, 32);
         look(exp, 8'h01 << i);
         xfer(stat_a[i], 1'h1, 16'hFFFF, 1'h0, 32);
         look(exp, 8'h01 << i);
      end
      pulse(5, 16'h1000);
      xfer(DEV_STAT_ADDR, 1'h1, 16'hFFFF, 1'h0, 32);
      look(16'h9000, 8'h00);
      // event lands well after the seventh clock of a read frame
      fork
         xfer(THERMAL_STATUS_REG_ADDR, 1'h0, 16'h0000, 1'h0, 32);
         begin
            #900;
            pulse(1, 16'h0004);
         end
      join
      look(16'h0000, 8'h00);
      xfer(THERMAL_STATUS_REG_ADDR, 1'h1, 16'hFFFF, 1'h0, 32);
      look(16'h0004, 8'h02);
      xfer(7'h11, 1'h1, 16'h0001, 1'h0, 16);
      check(wr_seen === wr_before, "short frame");
      xfer(7'h11, 1'h0, 16'h0000, 1'h0, 0);
      check(err === 1'h1, "err flag");
      xfer(7'h11, 1'h0, 16'h0000, 1'h0, 32);
      check(err === 1'h0, "err clear");
      @(posedge sys_clk);
      #1 crc_en = 1'h0;
      xfer(DEV_STAT_ADDR, 1'h0, 16'h0000, 1'h0, 32);
      look(16'h0000, 8'h00);
      xfer(7'h10, 1'h1, 16'h4321, 1'h1, 32);
      check(wr_seen === wr_before, "bad pattern");
      xfer(DEV_STAT_ADDR, 1'h1, 16'hFFFF, 1'h0, 32);
      look(16'h4000, 8'hA0);
      xfer(DEV_STAT_ADDR, 1'h0, 16'h0000, 1'h0, 32);
      look(16'h0000, 8'h00);
      // reset in mid-run: outputs drop and stored settings are lost
      @(posedge sys_clk);
      #1 rst = 1'h1;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'h0;
      repeat (8) @(posedge sys_clk);
      check({cfg_wr, cfg_addr, cfg_data, summary, oe} === '0, "mid reset");
      xfer(7'h10, 1'h0, 16'h0000, 1'h0, 32);
      look(16'h0000, 8'h00);
      report_and_stop;
   end
endmodule
